//--- shared/hpd_cfg.svh
// offsets, field positions, reset values and timing counts of the headphone driver block
// assumes core_clk at 25 MHz; included by the package and by both ends
`ifndef HPD_CFG_SVH
`define HPD_CFG_SVH

// device register offsets, page 0 (the page selector is reachable from both pages)
`define HPD_REG_PAGE       8'h00
`define HPD_REG_JACK       8'h0D
`define HPD_REG_OUTCFG     8'h0E
`define HPD_REG_SHORT_CTL  8'h26
`define HPD_REG_SOFTSTEP   8'h28
`define HPD_REG_PWRUP      8'h2A
`define HPD_REG_DRV        8'h2B
`define HPD_REG_SHORT_STAT 8'h5F
`define HPD_REG_GPIO0      8'h60
`define HPD_REG_GPIO1      8'h61
`define HPD_REG_GPIO_IN    8'h62
`define HPD_REG_IRQ_STAT   8'h63

// reset values
`define HPD_RST_ZERO       8'h00
`define HPD_RST_SOFTSTEP   8'h01
`define HPD_RST_SHORT_CTL  8'h04

// field positions
`define HPD_SC_DET_BIT     2
`define HPD_SC_AUTO_BIT    1
`define HPD_PWR_L_BIT      0
`define HPD_PWR_R_BIT      1
`define HPD_GP_TRAIN_BIT   3
`define HPD_GP_LEVEL_BIT   2

// gpio modes, bits 1:0 of a gpio register
`define HPD_GP_INPUT       2'h0
`define HPD_GP_DRIVE       2'h1
`define HPD_GP_CLOCK       2'h2
`define HPD_GP_IRQ         2'h3

// timing
`define HPD_CLK_HZ         25000000
`define HPD_TICK_MS        1
`define HPD_TICK_CYC       (`HPD_CLK_HZ / 1000 * `HPD_TICK_MS)
`define HPD_MAX_DELAY_MS   12'hFA0
`define HPD_ATTEN_MAX      4'hF
`define HPD_GAIN_MAX       4'h9

// host controller registers
`define HPD_H_ADDR         4'h0
`define HPD_H_WDATA        4'h1
`define HPD_H_GO           4'h2
`define HPD_H_RDATA        4'h3
`define HPD_H_STAT         4'h4
`define HPD_H_MASK         4'h5
`define HPD_H_BUSY         4'h6

`endif

//--- shared/hpd_link_if.sv
// link between the host controller and the headphone driver device
// assumes one core_clk for both ends; the testbench drives gpio_ext for undriven pins
`timescale 1ns/100ps

interface hpd_link_if;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic [7:0] bus_rdata;
    logic       bus_wr;
    logic       bus_rd;
    logic [1:0] gpio_out;
    logic [1:0] gpio_oe;
    logic [1:0] gpio_ext;
    logic [1:0] gpio_in;

    // pin level: driven value while enabled, else the outside level
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gpio_ext);

    modport dev  (input bus_addr, bus_wdata, bus_wr, bus_rd, gpio_in, output bus_rdata, gpio_out, gpio_oe);
    modport host (output bus_addr, bus_wdata, bus_wr, bus_rd, input bus_rdata, gpio_out, gpio_oe, gpio_in);
endinterface : hpd_link_if

//--- shared/hpd_pkg.sv
// types and shared decoding of the headphone driver block
// assumes hpd_cfg.svh is on the include path
`include "hpd_cfg.svh"

package hpd_pkg;

    typedef enum logic [3:0] {
        HPD_OFF  = 4'b0001,
        HPD_WAIT = 4'b0010,
        HPD_STEP = 4'b0100,
        HPD_ON   = 4'b1000
    } hpd_pwr_e;

    typedef enum logic [3:0] {
        HPD_H_IDLE = 4'b0001,
        HPD_H_CAPT = 4'b0010,
        HPD_H_RBK  = 4'b0100,
        HPD_H_CHK  = 4'b1000
    } hpd_host_e;

    // power-up delay in milliseconds for a 4-bit code, zero up to four seconds
    function automatic logic [11:0] hpd_delay_ms(input logic [3:0] code);
        unique case (code)
            4'h0: return 12'h000;
            4'h1: return 12'h001;
            4'h2: return 12'h002;
            4'h3: return 12'h005;
            4'h4: return 12'h00A;
            4'h5: return 12'h014;
            4'h6: return 12'h032;
            4'h7: return 12'h064;
            4'h8: return 12'h0C8;
            4'h9: return 12'h1F4;
            4'hA: return 12'h3E8;
            4'hB: return 12'h7D0;
            default: return `HPD_MAX_DELAY_MS;
        endcase
    endfunction : hpd_delay_ms

endpackage : hpd_pkg

//--- src/hpd_device.sv
// headphone driver power, short-circuit, jack and gpio interrupt control
// assumes the host end on hpd_link_if and asynchronous analog status inputs
//
// How it works
// - power-up delay selectable, zero to four seconds
// - host programs output type before powering drivers
// - powered-down pin condition selectable, three choices
// - soft-step attenuation down after power-up, default on
// - output level gain up to nine decibels
// - shorts limit current; protection status readable
// - auto shutdown holds off until off-on sequence
// - jack insertion and headset type readable
// - host enables short shutdown for differential detection
// - gpio as input, driven output, clock, interrupt
// - four interrupt sources routable or ORed, status
// - interrupt single pulse or train until read
// - every register eight bits, bit seven msb
// - page bit zero selects page, resets zero
// - host writes zeros to page upper bits
// - host reads page back after each page write
// - host restores driver settings by direct writes
`timescale 1ns/100ps
`include "hpd_cfg.svh"

module hpd_device import hpd_pkg::*; #(
    parameter int unsigned TICK_CYC = `HPD_TICK_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    hpd_link_if.dev         link,
    input  wire logic       short_l,
    input  wire logic       short_r,
    input  wire logic       jack_sense,
    input  wire logic [1:0] headset_type,
    input  wire logic       button,
    input  wire logic       agc_noise,
    output logic            left_headphone_en_q,
    output logic            right_headphone_en_q,
    output logic      [3:0] drv_gain_q,
    output logic      [3:0] drv_atten_q,
    output logic      [1:0] pd_cond_q,
    output logic      [1:0] out_cfg_type_q
);

    ////////////////////////////////////////////////////////////////////////////
    // registers, eight bits wide except the four-bit interrupt status
    logic [7:0] page_q;
    logic [7:0] outcfg_q;
    logic [7:0] short_ctl_q;
    logic [7:0] softstep_q;
    logic [7:0] pwrup_q;
    logic [7:0] drv_q;
    logic [7:0] gpio_cfg_q [2];
    logic [3:0] irq_stat_q;
    logic [7:0] rdata_q;

    function automatic logic p0_hit(input logic [7:0] a, input logic [7:0] r, input logic pg);
        return (a == r) && (!pg || r == `HPD_REG_PAGE);
    endfunction : p0_hit

    function automatic logic wr_hit(input logic [7:0] r);
        return link.bus_wr && p0_hit(link.bus_addr, r, page_q[0]);
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers and the millisecond tick
    logic [6:0]  sync_q;
    logic [1:0]  gpio_in_s;
    logic [14:0] div_q;
    logic        tick;

    hpd_sync3 #(.W(8)) u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .din      ({link.gpio_in[0], agc_noise, button, headset_type, jack_sense, short_r, short_l}),
        .dout_q   ({gpio_in_s[0], sync_q[6:0]})
    );
    hpd_sync3 #(.W(1)) u_sync_g1 (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .din      (link.gpio_in[1]),
        .dout_q   (gpio_in_s[1])
    );
    assign tick = (div_q == 15'(TICK_CYC - 1));

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) div_q <= '0;
        else if (tick) div_q <= '0;
        else div_q <= div_q + 15'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            page_q        <= `HPD_RST_ZERO;
            outcfg_q      <= `HPD_RST_ZERO;
            short_ctl_q   <= `HPD_RST_SHORT_CTL;
            softstep_q    <= `HPD_RST_SOFTSTEP;
            pwrup_q       <= `HPD_RST_ZERO;
            drv_q         <= `HPD_RST_ZERO;
            gpio_cfg_q[0] <= `HPD_RST_ZERO;
            gpio_cfg_q[1] <= `HPD_RST_ZERO;
        end else begin
            if (wr_hit(`HPD_REG_PAGE))      page_q      <= {7'h00, link.bus_wdata[0]};
            if (wr_hit(`HPD_REG_OUTCFG))    outcfg_q    <= link.bus_wdata;
            if (wr_hit(`HPD_REG_SHORT_CTL)) short_ctl_q <= link.bus_wdata;
            if (wr_hit(`HPD_REG_SOFTSTEP))  softstep_q  <= link.bus_wdata;
            if (wr_hit(`HPD_REG_PWRUP))     pwrup_q     <= link.bus_wdata;
            if (wr_hit(`HPD_REG_DRV))       drv_q       <= link.bus_wdata;
            if (wr_hit(`HPD_REG_GPIO0))     gpio_cfg_q[0] <= link.bus_wdata;
            if (wr_hit(`HPD_REG_GPIO1))     gpio_cfg_q[1] <= link.bus_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // short-circuit protection
    logic [1:0] sc_live;
    logic [1:0] sc_flag_q;
    logic [1:0] shut_q;
    logic [1:0] drv_on;
    logic [1:0] pwr_off_wr;

    assign sc_live    = sync_q[1:0] & {2{short_ctl_q[`HPD_SC_DET_BIT]}};
    assign pwr_off_wr = {2{link.bus_wr && p0_hit(link.bus_addr, `HPD_REG_DRV, page_q[0])}} & ~link.bus_wdata[1:0];
    assign drv_on     = {right_headphone_en_q, left_headphone_en_q};

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sc_flag_q <= 2'h0;
            shut_q    <= 2'h0;
        end else begin
            // clear on power-down write, a fresh short still wins
            sc_flag_q <= (sc_flag_q & ~pwr_off_wr) | (sc_live & drv_on);
            shut_q    <= (shut_q & ~pwr_off_wr)
                       | (sc_live & drv_on & {2{short_ctl_q[`HPD_SC_AUTO_BIT]}});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-up sequencing
    hpd_pwr_e   st_q;
    logic [11:0] cnt_q;
    logic       pwr_req;
    logic [1:0] drv_want;

    assign drv_want = drv_q[1:0] & ~shut_q;
    assign pwr_req  = |drv_want;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q        <= HPD_OFF;
            cnt_q       <= 12'h000;
            drv_atten_q <= `HPD_ATTEN_MAX;
        end else begin
            unique case (st_q)
                HPD_OFF: begin
                    drv_atten_q <= `HPD_ATTEN_MAX;
                    if (pwr_req) begin
                        st_q  <= HPD_WAIT;
                        cnt_q <= hpd_delay_ms(pwrup_q[3:0]);
                    end
                end
                HPD_WAIT: begin
                    if (!pwr_req) st_q <= HPD_OFF;
                    else if (cnt_q == 12'h000) begin
                        if (softstep_q[0]) st_q <= HPD_STEP;
                        else begin
                            st_q        <= HPD_ON;
                            drv_atten_q <= 4'h0;
                        end
                    end else if (tick) cnt_q <= cnt_q - 12'h001;
                end
                HPD_STEP: begin
                    if (!pwr_req) st_q <= HPD_OFF;
                    else if (drv_atten_q == 4'h0) st_q <= HPD_ON;
                    else if (tick) drv_atten_q <= drv_atten_q - 4'h1;
                end
                HPD_ON: begin
                    if (!pwr_req) st_q <= HPD_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            left_headphone_en_q  <= 1'b0;
            right_headphone_en_q <= 1'b0;
            drv_gain_q           <= 4'h0;
            pd_cond_q            <= 2'h0;
            out_cfg_type_q       <= 2'h0;
        end else begin
            left_headphone_en_q  <= (st_q == HPD_STEP || st_q == HPD_ON) && drv_want[0];
            right_headphone_en_q <= (st_q == HPD_STEP || st_q == HPD_ON) && drv_want[1];
            drv_gain_q           <= (drv_q[7:4] > `HPD_GAIN_MAX) ? `HPD_GAIN_MAX : drv_q[7:4];
            // 0 three-state, 1 weak common mode, 2 weak half supply, 3 as 0
            pd_cond_q            <= (pwrup_q[5:4] == 2'h3) ? 2'h0 : pwrup_q[5:4];
            out_cfg_type_q       <= outcfg_q[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt causes: jack change, short, button, noise
    logic [3:0] ev;
    logic [3:0] prev_q;
    logic       irq_rd;

    assign ev     = {sync_q[6] & ~prev_q[3], sync_q[5] & ~prev_q[2],
                     (|sc_live) & ~prev_q[1], sync_q[2] ^ prev_q[0]};
    assign irq_rd = link.bus_rd && p0_hit(link.bus_addr, `HPD_REG_IRQ_STAT, page_q[0]);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q     <= 4'h0;
            irq_stat_q <= 4'h0;
        end else begin
            prev_q     <= {sync_q[6], sync_q[5], |sc_live, sync_q[2]};
            irq_stat_q <= (irq_stat_q & ~{4{irq_rd}}) | ev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gpio pins
    logic [1:0] gp_out_q;
    logic [1:0] gp_oe_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            gp_out_q <= 2'h0;
            gp_oe_q  <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                gp_oe_q[i] <= (gpio_cfg_q[i][1:0] != `HPD_GP_INPUT);
                unique case (gpio_cfg_q[i][1:0])
                    `HPD_GP_INPUT: gp_out_q[i] <= 1'b0;
                    `HPD_GP_DRIVE: gp_out_q[i] <= gpio_cfg_q[i][`HPD_GP_LEVEL_BIT];
                    `HPD_GP_CLOCK: gp_out_q[i] <= tick ? ~gp_out_q[i] : gp_out_q[i];
                    `HPD_GP_IRQ: begin
                        if (!gpio_cfg_q[i][`HPD_GP_TRAIN_BIT])
                            gp_out_q[i] <= |(ev & gpio_cfg_q[i][7:4]);
                        else if (irq_rd || !(|(irq_stat_q & gpio_cfg_q[i][7:4])))
                            gp_out_q[i] <= 1'b0;
                        else if (tick)
                            gp_out_q[i] <= ~gp_out_q[i];
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; unmapped and page 1 read zero, except the page selector
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) rdata_q <= 8'h00;
        else if (link.bus_rd) begin
            rdata_q <= 8'h00;
            if (p0_hit(link.bus_addr, `HPD_REG_PAGE, page_q[0]))       rdata_q <= page_q;
            if (p0_hit(link.bus_addr, `HPD_REG_JACK, page_q[0]))       rdata_q <= {5'h00, sync_q[2], sync_q[4:3]};
            if (p0_hit(link.bus_addr, `HPD_REG_OUTCFG, page_q[0]))     rdata_q <= outcfg_q;
            if (p0_hit(link.bus_addr, `HPD_REG_SHORT_CTL, page_q[0]))  rdata_q <= short_ctl_q;
            if (p0_hit(link.bus_addr, `HPD_REG_SOFTSTEP, page_q[0]))   rdata_q <= softstep_q;
            if (p0_hit(link.bus_addr, `HPD_REG_PWRUP, page_q[0]))      rdata_q <= pwrup_q;
            if (p0_hit(link.bus_addr, `HPD_REG_DRV, page_q[0]))        rdata_q <= drv_q;
            if (p0_hit(link.bus_addr, `HPD_REG_SHORT_STAT, page_q[0])) rdata_q <= {2'h0, shut_q, sc_flag_q, sc_live};
            if (p0_hit(link.bus_addr, `HPD_REG_GPIO0, page_q[0]))      rdata_q <= gpio_cfg_q[0];
            if (p0_hit(link.bus_addr, `HPD_REG_GPIO1, page_q[0]))      rdata_q <= gpio_cfg_q[1];
            if (p0_hit(link.bus_addr, `HPD_REG_GPIO_IN, page_q[0]))    rdata_q <= {6'h00, gpio_in_s};
            if (p0_hit(link.bus_addr, `HPD_REG_IRQ_STAT, page_q[0]))   rdata_q <= {4'h0, irq_stat_q};
        end
    end

    assign link.bus_rdata = rdata_q;
    assign link.gpio_out  = gp_out_q;
    assign link.gpio_oe   = gp_oe_q;

endmodule : hpd_device

//--- src/hpd_host.sv
// host controller: software orders single register transfers to the device
// assumes the device end on hpd_link_if, same core_clk
`timescale 1ns/100ps
`include "hpd_cfg.svh"

module hpd_host import hpd_pkg::*; (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    hpd_link_if.host        link,
    input  wire logic [3:0] u_addr,
    input  wire logic [7:0] u_wdata,
    input  wire logic       u_wr,
    input  wire logic       u_rd,
    output logic      [7:0] u_rdata_q,
    output logic            irq_q
);
    hpd_host_e  st_q;
    logic [7:0] tgt_q;
    logic [7:0] wd_q;
    logic [7:0] rd_q;
    logic [3:0] stat_q;
    logic [3:0] mask_q;
    logic [7:0] baddr_q;
    logic [7:0] bwdata_q;
    logic       bwr_q;
    logic       brd_q;
    logic [1:0] gp_prev_q;
    logic [3:0] ev;
    logic       go_wr;
    logic       go_rd;
    logic       done;
    logic       mismatch;
    logic [1:0] gp_irq;

    assign go_wr    = u_wr && u_addr == `HPD_H_GO && u_wdata[0] && st_q == HPD_H_IDLE && !bwr_q;
    assign go_rd    = u_wr && u_addr == `HPD_H_GO && u_wdata[1] && !u_wdata[0] && st_q == HPD_H_IDLE && !bwr_q;
    assign gp_irq   = link.gpio_out & link.gpio_oe;
    assign mismatch = st_q == HPD_H_CHK && link.bus_rdata[0] != bwdata_q[0];
    assign done     = (st_q == HPD_H_IDLE && bwr_q && baddr_q != `HPD_REG_PAGE) ||
                      (st_q == HPD_H_CAPT && !brd_q) || st_q == HPD_H_CHK;
    assign ev       = {mismatch, gp_irq & ~gp_prev_q, done};

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tgt_q     <= 8'h00;
            wd_q      <= 8'h00;
            mask_q    <= 4'h0;
            stat_q    <= 4'h0;
            gp_prev_q <= 2'h0;
            u_rdata_q <= 8'h00;
            irq_q     <= 1'b0;
        end else begin
            if (u_wr && u_addr == `HPD_H_ADDR)  tgt_q  <= u_wdata;
            if (u_wr && u_addr == `HPD_H_WDATA) wd_q   <= u_wdata;
            if (u_wr && u_addr == `HPD_H_MASK)  mask_q <= u_wdata[3:0];
            stat_q    <= (stat_q & ~({4{u_wr && u_addr == `HPD_H_STAT}} & u_wdata[3:0])) | ev;
            gp_prev_q <= gp_irq;
            irq_q     <= |(((stat_q & ~({4{u_wr && u_addr == `HPD_H_STAT}} & u_wdata[3:0])) | ev) & mask_q);
            if (u_rd) begin
                unique case (u_addr)
                    `HPD_H_ADDR:  u_rdata_q <= tgt_q;
                    `HPD_H_WDATA: u_rdata_q <= wd_q;
                    `HPD_H_RDATA: u_rdata_q <= rd_q;
                    `HPD_H_STAT:  u_rdata_q <= {4'h0, stat_q};
                    `HPD_H_MASK:  u_rdata_q <= {4'h0, mask_q};
                    `HPD_H_BUSY:  u_rdata_q <= {7'h00, st_q != HPD_H_IDLE || bwr_q};
                    default:      u_rdata_q <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer sequencer; a page write is followed by a read-back
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q     <= HPD_H_IDLE;
            baddr_q  <= 8'h00;
            bwdata_q <= 8'h00;
            bwr_q    <= 1'b0;
            brd_q    <= 1'b0;
            rd_q     <= 8'h00;
        end else begin
            bwr_q <= 1'b0;
            brd_q <= 1'b0;
            unique case (st_q)
                HPD_H_IDLE: begin
                    if (bwr_q && baddr_q == `HPD_REG_PAGE) begin
                        brd_q <= 1'b1;
                        st_q  <= HPD_H_RBK;
                    end else if (go_wr) begin
                        baddr_q  <= tgt_q;
                        bwdata_q <= (tgt_q == `HPD_REG_PAGE) ? {7'h00, wd_q[0]} : wd_q;
                        bwr_q    <= 1'b1;
                    end else if (go_rd) begin
                        baddr_q <= tgt_q;
                        brd_q   <= 1'b1;
                        st_q    <= HPD_H_CAPT;
                    end
                end
                HPD_H_CAPT: begin
                    // read data stand the cycle after the strobe
                    if (!brd_q) begin
                        rd_q <= link.bus_rdata;
                        st_q <= HPD_H_IDLE;
                    end
                end
                HPD_H_RBK: st_q <= HPD_H_CHK;
                HPD_H_CHK: begin
                    rd_q <= link.bus_rdata;
                    st_q <= HPD_H_IDLE;
                end
            endcase
        end
    end

    assign link.bus_addr  = baddr_q;
    assign link.bus_wdata = bwdata_q;
    assign link.bus_wr    = bwr_q;
    assign link.bus_rd    = brd_q;

endmodule : hpd_host

//--- src/hpd_sync3.sv
// three-stage synchroniser; output moves once stages two and three agree
// assumes inputs asynchronous to core_clk
`timescale 1ns/100ps

module hpd_sync3 #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            dout_q <= '0;
        end else begin
            s1_q   <= din;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            dout_q <= (s2_q & s3_q) | (dout_q & (s2_q | s3_q));
        end
    end
endmodule : hpd_sync3

//--- verif/hp_driver_power_fault_irq_ctrl_tb_top.sv
// testbench for host and device joined by hpd_link_if
// assumes 25 MHz core_clk and a shortened 1 ms tick
`timescale 1ns/100ps

module hp_driver_power_fault_irq_ctrl_tb_top;
    logic       core_clk, arst_n, u_wr, u_rd, irq, l_en, r_en;
    logic       short_l, short_r, jack_sense, button, agc_noise;
    logic [1:0] headset_type, pd_cond, out_cfg;
    logic [3:0] u_addr, gain, atten;
    logic [7:0] u_wdata, u_rdata;
    int         n_fail, checks, cyc;
    hpd_link_if link_if ();
    hpd_device #(.TICK_CYC(4)) i_hpd_device (.core_clk(core_clk), .arst_n(arst_n), .link(link_if),
        .short_l(short_l), .short_r(short_r), .jack_sense(jack_sense), .headset_type(headset_type),
        .button(button), .agc_noise(agc_noise), .left_headphone_en_q(l_en), .right_headphone_en_q(r_en),
        .drv_gain_q(gain), .drv_atten_q(atten), .pd_cond_q(pd_cond), .out_cfg_type_q(out_cfg));
    hpd_host i_hpd_host (.core_clk(core_clk), .arst_n(arst_n), .link(link_if), .u_addr(u_addr),
        .u_wdata(u_wdata), .u_wr(u_wr), .u_rd(u_rd), .u_rdata_q(u_rdata), .irq_q(irq));
    hpd_chk i_hpd_chk (.core_clk(core_clk), .arst_n(arst_n), .bus_addr(link_if.bus_addr),
        .bus_wdata(link_if.bus_wdata), .bus_rdata(link_if.bus_rdata), .bus_wr(link_if.bus_wr),
        .bus_rd(link_if.bus_rd), .gpio_oe(link_if.gpio_oe));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic uw(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {u_addr, u_wdata, u_wr, u_rd} <= {a, d, 2'b10};
    endtask : uw
    task automatic settle(input int n);
        @(posedge core_clk);
        u_wr <= 1'b0;
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle
    // software orders one device transfer: target, data, go
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic [7:0] op);
        uw(4'h0, a);
        uw(4'h1, d);
        uw(4'h2, op);
        settle(8);
    endtask : xfer
    task automatic drd(input string name, input logic [7:0] a, input logic [7:0] exp);
        xfer(a, 8'h00, 8'h02);
        @(posedge core_clk);
        {u_addr, u_wr, u_rd} <= {4'h3, 2'b01};
        @(posedge core_clk);
        u_rd <= 1'b0;
        @(negedge core_clk);
        chk(name, u_rdata, exp);
    endtask : drd
    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        {arst_n, u_addr, u_wdata, u_wr, u_rd, short_l, short_r, jack_sense, button, agc_noise} = '0;
        headset_type = 2'h0;
        link_if.gpio_ext = 2'h0;
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        drd("page", 8'h00, 8'h00);
        drd("short_ctl", 8'h26, 8'h04);
        drd("softstep", 8'h28, 8'h01);
        xfer(8'h00, 8'hFF, 8'h01);
        drd("page_one", 8'h00, 8'h01);
        drd("page_one_other", 8'h26, 8'h00);
        xfer(8'h00, 8'h00, 8'h01);
        xfer(8'h0E, 8'h02, 8'h01);
        chk("out_cfg", out_cfg, 8'h02);
        xfer(8'h2A, 8'h20, 8'h01);
        chk("pd_cond", pd_cond, 8'h02);
        xfer(8'h2B, 8'hF1, 8'h01);
        chk("atten_early", atten == 4'h0, 8'h00);
        settle(80);
        chk("powered", {r_en, l_en}, 8'h01);
        chk("gain", gain, 8'h09);
        chk("atten", atten, 8'h00);
        xfer(8'h26, 8'h06, 8'h01);
        short_l <= 1'b1;
        settle(10);
        chk("auto_off", l_en, 8'h00);
        drd("short_stat", 8'h5F, 8'h15);
        short_l <= 1'b0;
        xfer(8'h2B, 8'hF0, 8'h01);
        drd("short_clr", 8'h5F, 8'h00);
        xfer(8'h2B, 8'hF1, 8'h01);
        settle(80);
        chk("repowered", l_en, 8'h01);
        xfer(8'h63, 8'h00, 8'h02);
        xfer(8'h60, 8'h13, 8'h01);
        uw(4'h4, 8'hFF);
        uw(4'h5, 8'h02);
        {jack_sense, headset_type} <= 3'b110;
        settle(10);
        chk("irq_set", irq, 8'h01);
        drd("jack", 8'h0D, 8'h06);
        drd("irq_stat", 8'h63, 8'h01);
        drd("irq_cleared", 8'h63, 8'h00);
        uw(4'h4, 8'h02);
        settle(3);
        chk("irq_clr", irq, 8'h00);
        xfer(8'h61, 8'h05, 8'h01);
        drd("gpio_drive", 8'h62, 8'h02);
        xfer(8'h61, 8'h00, 8'h01);
        link_if.gpio_ext <= 2'h3;
        drd("gpio_input", 8'h62, 8'h02);
        xfer(8'h61, 8'h4B, 8'h01);
        uw(4'h4, 8'hFF);
        uw(4'h5, 8'h04);
        button <= 1'b1;
        settle(16);
        chk("train_irq", irq, 8'h01);
        drd("train_src", 8'h63, 8'h04);
        drd("train_stop", 8'h62, 8'h00);
        conclude();
    end
endmodule : hp_driver_power_fault_irq_ctrl_tb_top

//--- verif/hpd_chk.sv
// link checker for the headphone driver block
// assumes one core_clk; instantiated beside hpd_link_if
`timescale 1ns/100ps

module hpd_chk (
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [1:0] gpio_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic page_q;
    wire  pg_wr = bus_wr && bus_addr == 8'h00;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) page_q <= 1'b0;
        else if (pg_wr) page_q <= bus_wdata[0];
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_excl; !(bus_wr && bus_rd); endproperty
    a_excl: assert property (p_excl) else $error("both strobes high");
    property p_page_zero; pg_wr |-> bus_wdata[7:1] == 7'h00; endproperty
    a_page_zero: assert property (p_page_zero) else $error("page upper bits set");
    property p_page_rbk; pg_wr |=> bus_rd && bus_addr == 8'h00; endproperty
    a_page_rbk: assert property (p_page_rbk) else $error("no page readback");
    property p_page_echo; pg_wr ##1 bus_rd |=> bus_rdata == {7'h00, $past(bus_wdata[0], 2)}; endproperty
    a_page_echo: assert property (p_page_echo) else $error("page readback wrong");
    property p_page1_zero; bus_rd && page_q && bus_addr != 8'h00 |=> bus_rdata == 8'h00; endproperty
    a_page1_zero: assert property (p_page1_zero) else $error("page one read not zero");
    property p_rd_hold; !$past(bus_rd) |-> $stable(bus_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_wr_pulse; bus_wr |=> !bus_wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    property p_oe_cause; $changed(gpio_oe) |-> $past(bus_wr, 2) && $past(bus_addr[7:1], 2) == 7'h30; endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
    c_page_rbk: cover property (pg_wr ##1 bus_rd);
    c_page1: cover property (bus_rd && page_q);
    c_oe: cover property ($rose(gpio_oe[1]));
endmodule : hpd_chk
